/* File: include/zone_lock_pkg.sv */
package zone_lock_pkg;
  localparam int NUM_ZONES = 4;
  localparam int ZONE_BITS = 256;
  localparam logic [3:0] OP_ZONE_LOCK = 4'h7;
  localparam logic [3:0] OP_FREEZE = 4'h1;
  localparam logic [3:0] OP_MEM_WRITE = 4'ha;
  localparam logic [7:0] ZONE0_WRITE_LOCK_OFS = 8'h01;
  localparam logic [7:0] ZONE1_WRITE_LOCK_OFS = 8'h02;
  localparam logic [7:0] ZONE2_WRITE_LOCK_OFS = 8'h04;
  localparam logic [7:0] ZONE3_WRITE_LOCK_OFS = 8'h08;
  localparam logic [3:0] ZONE_LOCK_RESET = 4'h0;
  localparam logic [7:0] LOCK_DATA_KEY = 8'hff;
  localparam logic [7:0] FREEZE_ADDR_KEY = 8'h55;
  localparam logic [7:0] FREEZE_DATA_KEY = 8'haa;
  localparam logic [7:0] READ_UNLOCKED = 8'h00;
  localparam logic [7:0] READ_LOCKED = 8'hff;
  localparam int ZONE_ADDR_MSB = 6;
  localparam int ZONE_ADDR_LSB = 5;
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int INTERNAL_WRITE_CYCLE_TIME_US = 1000;
  localparam int WRITE_CYCLE_CLKS = (INTERNAL_WRITE_CYCLE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int INTERRUPT_DISCHARGE_TIME_US = 150;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_DEVADR = 4'b0001,
    S_ZSEL = 4'b0010,
    S_ZDATA = 4'b0011,
    S_ZSTOP = 4'b0100,
    S_ZREAD = 4'b0101,
    S_FADR = 4'b0110,
    S_FDATA = 4'b0111,
    S_FSTOP = 4'b1000,
    S_WADR = 4'b1001,
    S_WDATA = 4'b1010,
    S_BUSY = 4'b1011
  } zl_state_t;
endpackage

/* File: logic/eeprom_zone_write_lock.sv */
`timescale 1ns/10ps
module eeprom_zone_write_lock #(
  parameter int WRITE_CYCLES = zone_lock_pkg::WRITE_CYCLE_CLKS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] dev_addr,
  input wire logic frame_start,
  input wire logic frame_stop,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_req,
  input wire logic [zone_lock_pkg::NUM_ZONES-1:0] nv_zone_lock,
  input wire logic nv_frozen,
  output logic ack_valid,
  output logic ack_nack,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic busy,
  output logic mem_wr_en,
  output logic [6:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic nv_prog_en,
  output logic [zone_lock_pkg::NUM_ZONES-1:0] nv_prog_mask,
  output logic nv_prog_freeze
);
  import zone_lock_pkg::*;

  // One-hot selector decode; the upper nibble never takes part.
  function automatic logic [2:0] sel_decode(input logic [7:0] sel);
    logic [2:0] r;
    r = 3'b000;
    case (sel[3:0])
      ZONE0_WRITE_LOCK_OFS[3:0]: r = 3'b100;
      ZONE1_WRITE_LOCK_OFS[3:0]: r = 3'b101;
      ZONE2_WRITE_LOCK_OFS[3:0]: r = 3'b110;
      ZONE3_WRITE_LOCK_OFS[3:0]: r = 3'b111;
      default: r = 3'b000;
    endcase
    return r;
  endfunction

  zl_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0] sel_reg, sel_next;
  logic sel_ok_reg, sel_ok_next;
  logic pend_freeze_reg, pend_freeze_next;
  logic ack_valid_reg, ack_valid_next;
  logic ack_nack_reg, ack_nack_next;
  logic tx_valid_reg, tx_valid_next;
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic mem_wr_en_reg, mem_wr_en_next;
  logic [6:0] mem_wr_addr_reg, mem_wr_addr_next;
  logic [7:0] mem_wr_data_reg, mem_wr_data_next;
  logic nv_prog_en_reg, nv_prog_en_next;
  logic [NUM_ZONES-1:0] nv_prog_mask_reg, nv_prog_mask_next;
  logic nv_prog_freeze_reg, nv_prog_freeze_next;
  // Busy is registered so the pin never shows a glitch from the state decode.
  logic busy_reg, busy_next;
  logic [2:0] sel_dec;
  logic [1:0] wr_zone;
  logic addr_hit;

  assign sel_dec = sel_decode(sel_reg);
  assign wr_zone = mem_wr_addr_reg[ZONE_ADDR_MSB:ZONE_ADDR_LSB];
  assign addr_hit = (rx_byte[3:1] == dev_addr);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sel_next = sel_reg;
    sel_ok_next = sel_ok_reg;
    pend_freeze_next = pend_freeze_reg;
    ack_valid_next = 1'b0;
    ack_nack_next = ack_nack_reg;
    tx_valid_next = 1'b0;
    tx_byte_next = tx_byte_reg;
    mem_wr_en_next = 1'b0;
    mem_wr_addr_next = mem_wr_addr_reg;
    mem_wr_data_next = mem_wr_data_reg;
    nv_prog_en_next = 1'b0;
    nv_prog_mask_next = nv_prog_mask_reg;
    nv_prog_freeze_next = nv_prog_freeze_reg;
    if (state_reg == S_BUSY) begin
      // The line is not watched at all here; a master interrupting the cycle is its own risk.
      if (cnt_reg == 32'(WRITE_CYCLES - 1)) begin
        state_next = S_IDLE;
        cnt_next = 32'h0;
        nv_prog_en_next = !nv_frozen;
        nv_prog_freeze_next = pend_freeze_reg;
        nv_prog_mask_next = '0;
        if (!pend_freeze_reg && sel_dec[2]) begin
          nv_prog_mask_next[sel_dec[1:0]] = 1'b1;
        end
      end else begin
        cnt_next = cnt_reg + 32'h1;
      end
    end else if (frame_stop) begin
      state_next = S_IDLE;
      sel_ok_next = 1'b0;
      if (state_reg == S_ZSTOP) begin
        state_next = S_BUSY;
        pend_freeze_next = 1'b0;
      end else if (state_reg == S_FSTOP) begin
        state_next = S_BUSY;
        pend_freeze_next = 1'b1;
      end
    end else if (frame_start) begin
      state_next = S_DEVADR;
      if (state_reg != S_ZDATA) begin
        sel_ok_next = 1'b0;
      end
    end else if (tx_req && state_reg == S_ZREAD) begin
      tx_valid_next = 1'b1;
      tx_byte_next = nv_zone_lock[sel_dec[1:0]] ? READ_LOCKED : READ_UNLOCKED;
    end else if (rx_valid) begin
      ack_valid_next = 1'b1;
      ack_nack_next = 1'b0;
      state_next = S_IDLE;
      case (state_reg)
        S_DEVADR: begin
          if (!addr_hit) begin
            ack_valid_next = 1'b0;
          end else if (rx_byte[7:4] == OP_ZONE_LOCK && !rx_byte[0]) begin
            state_next = S_ZSEL;
          end else if (rx_byte[7:4] == OP_ZONE_LOCK) begin
            ack_nack_next = !sel_ok_reg;
            state_next = sel_ok_reg ? S_ZREAD : S_IDLE;
          end else if (rx_byte[7:4] == OP_FREEZE && !rx_byte[0]) begin
            ack_nack_next = nv_frozen;
            state_next = nv_frozen ? S_IDLE : S_FADR;
          end else if (rx_byte[7:4] == OP_MEM_WRITE && !rx_byte[0]) begin
            state_next = S_WADR;
          end else begin
            ack_valid_next = 1'b0;
          end
        end
        S_ZSEL: begin
          sel_next = rx_byte;
          sel_ok_next = sel_decode(rx_byte) != 3'b000;
          ack_nack_next = sel_decode(rx_byte) == 3'b000;
          state_next = (sel_decode(rx_byte) == 3'b000) ? S_IDLE : S_ZDATA;
        end
        S_ZDATA: begin
          sel_ok_next = 1'b0;
          ack_nack_next = (rx_byte != LOCK_DATA_KEY) || nv_frozen;
          state_next = ack_nack_next ? S_IDLE : S_ZSTOP;
        end
        S_FADR: begin
          ack_nack_next = rx_byte != FREEZE_ADDR_KEY;
          state_next = ack_nack_next ? S_IDLE : S_FDATA;
        end
        S_FDATA: begin
          ack_nack_next = rx_byte != FREEZE_DATA_KEY;
          state_next = ack_nack_next ? S_IDLE : S_FSTOP;
        end
        S_WADR: begin
          mem_wr_addr_next = rx_byte[6:0];
          state_next = S_WDATA;
        end
        S_WDATA: begin
          // Zone comes from address bits 6:5, so each zone spans 32 bytes.
          ack_nack_next = nv_zone_lock[wr_zone];
          mem_wr_en_next = !nv_zone_lock[wr_zone];
          mem_wr_data_next = rx_byte;
        end
        default: begin
          ack_valid_next = 1'b0;
        end
      endcase
    end
    busy_next = (state_next == S_BUSY);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 32'h0;
      sel_reg <= 8'h00;
      sel_ok_reg <= 1'b0;
      pend_freeze_reg <= 1'b0;
      ack_valid_reg <= 1'b0;
      ack_nack_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      mem_wr_en_reg <= 1'b0;
      mem_wr_addr_reg <= 7'h00;
      mem_wr_data_reg <= 8'h00;
      nv_prog_en_reg <= 1'b0;
      nv_prog_mask_reg <= ZONE_LOCK_RESET;
      nv_prog_freeze_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
      sel_ok_reg <= sel_ok_next;
      pend_freeze_reg <= pend_freeze_next;
      ack_valid_reg <= ack_valid_next;
      ack_nack_reg <= ack_nack_next;
      tx_valid_reg <= tx_valid_next;
      tx_byte_reg <= tx_byte_next;
      mem_wr_en_reg <= mem_wr_en_next;
      mem_wr_addr_reg <= mem_wr_addr_next;
      mem_wr_data_reg <= mem_wr_data_next;
      nv_prog_en_reg <= nv_prog_en_next;
      nv_prog_mask_reg <= nv_prog_mask_next;
      nv_prog_freeze_reg <= nv_prog_freeze_next;
      busy_reg <= busy_next;
    end
  end

  assign ack_valid = ack_valid_reg;
  assign ack_nack = ack_nack_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_byte = tx_byte_reg;
  assign busy = busy_reg;
  assign mem_wr_en = mem_wr_en_reg;
  assign mem_wr_addr = mem_wr_addr_reg;
  assign mem_wr_data = mem_wr_data_reg;
  assign nv_prog_en = nv_prog_en_reg;
  assign nv_prog_mask = nv_prog_mask_reg;
  assign nv_prog_freeze = nv_prog_freeze_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_busy_ignores;
    busy && rx_valid |=> !ack_valid;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("Byte answered during write cycle.");

  property p_busy_len;
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("Write cycle ended too early.");

  property p_onehot_mask;
    nv_prog_en && !nv_prog_freeze |-> $onehot0(nv_prog_mask);
  endproperty
  a_onehot_mask: assert property (p_onehot_mask) else $error("More than one zone programmed.");

  property p_frozen_no_prog;
    $rose(nv_prog_en) |-> !$past(nv_frozen);
  endproperty
  a_frozen_no_prog: assert property (p_frozen_no_prog) else $error("Lock change while frozen.");

  property p_locked_nack;
    state_reg == S_WDATA && rx_valid && !frame_start && !frame_stop && nv_zone_lock[wr_zone]
      |=> ack_valid && ack_nack && !mem_wr_en;
  endproperty
  a_locked_nack: assert property (p_locked_nack) else $error("Locked zone write not refused.");

  property p_wadr_ack;
    state_reg == S_WADR && rx_valid && !frame_start && !frame_stop |=> ack_valid && !ack_nack;
  endproperty
  a_wadr_ack: assert property (p_wadr_ack) else $error("Word address not acknowledged.");

  property p_read_value;
    tx_valid |-> tx_byte == READ_LOCKED || tx_byte == READ_UNLOCKED;
  endproperty
  a_read_value: assert property (p_read_value) else $error("Bad lock query data.");

  property p_freeze_nack;
    state_reg == S_DEVADR && rx_valid && !frame_start && !frame_stop && addr_hit
      && rx_byte[7:4] == OP_FREEZE && !rx_byte[0] |=> ack_valid && ack_nack == $past(nv_frozen);
  endproperty
  a_freeze_nack: assert property (p_freeze_nack) else $error("Freeze opcode answer wrong.");

  property p_key_nack;
    state_reg == S_FADR && rx_valid && !frame_start && !frame_stop && rx_byte != FREEZE_ADDR_KEY
      |=> ack_nack ##1 !busy;
  endproperty
  a_key_nack: assert property (p_key_nack) else $error("Wrong freeze key accepted.");

  property p_stop_abort;
    frame_stop && !busy && state_reg != S_ZSTOP && state_reg != S_FSTOP |=> !busy [*2];
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("Misplaced Stop started a write.");

  property p_read_locked;
    tx_req && state_reg == S_ZREAD && !frame_start && !frame_stop && nv_zone_lock[sel_dec[1:0]]
      |=> tx_valid && tx_byte == READ_LOCKED;
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("Locked zone not reported.");

  property p_read_unlocked;
    tx_req && state_reg == S_ZREAD && !frame_start && !frame_stop && !nv_zone_lock[sel_dec[1:0]]
      |=> tx_valid && tx_byte == READ_UNLOCKED;
  endproperty
  a_read_unlocked: assert property (p_read_unlocked) else $error("Open zone not reported.");

  property p_unlocked_write;
    state_reg == S_WDATA && rx_valid && !frame_start && !frame_stop && !nv_zone_lock[wr_zone]
      |=> ack_valid && !ack_nack && mem_wr_en;
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("Open zone write refused.");

  property p_bad_sel_nack;
    state_reg == S_ZSEL && rx_valid && !frame_start && !frame_stop && !$onehot(rx_byte[3:0])
      |=> ack_valid && ack_nack;
  endproperty
  a_bad_sel_nack: assert property (p_bad_sel_nack) else $error("Bad selector accepted.");

  property p_good_sel_ack;
    state_reg == S_ZSEL && rx_valid && !frame_start && !frame_stop && $onehot(rx_byte[3:0])
      |=> ack_valid && !ack_nack;
  endproperty
  a_good_sel_ack: assert property (p_good_sel_ack) else $error("Valid selector refused.");

  property p_stop_starts_write;
    frame_stop && !busy && (state_reg == S_ZSTOP || state_reg == S_FSTOP) |=> busy;
  endproperty
  a_stop_starts_write: assert property (p_stop_starts_write) else $error("Write not started.");

  property p_cycle_end_prog;
    $fell(busy) |-> nv_prog_en == !$past(nv_frozen);
  endproperty
  a_cycle_end_prog: assert property (p_cycle_end_prog) else $error("Cycle end programming wrong.");
endmodule

/* File: testbench/link_master_model.sv */
`timescale 1ns/10ps
module link_master_model (
  input wire logic core_clk,
  output logic frame_start,
  output logic frame_stop,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_req
);
  initial begin
    frame_start = 1'b0;
    frame_stop = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_req = 1'b0;
  end

  // One link event per call: 0 start, 1 stop, 2 byte, 3 read request.
  // Called just after a rising edge, it holds one edge and then lets go.
  // Only the event's own strobe, plus rx_byte for a byte, is touched, so back-to-back calls never drive one signal twice.
  task automatic ev(input int kind, input logic [7:0] b);
    case (kind)
      0: frame_start = 1'b1;
      1: frame_stop = 1'b1;
      2: begin
        rx_valid = 1'b1;
        rx_byte = b;
      end
      default: tx_req = 1'b1;
    endcase
    @(posedge core_clk);
    #1;
    case (kind)
      0: frame_start = 1'b0;
      1: frame_stop = 1'b0;
      2: begin
        rx_valid = 1'b0;
        // A released byte shows no stale value to the device.
        rx_byte = ~b;
      end
      default: tx_req = 1'b0;
    endcase
  endtask
  // The model has no busy input; it starts an event whenever it is called, busy or not.
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import zone_lock_pkg::*;
  localparam int WC = 12;
  localparam logic [2:0] DEV = 3'h5;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic frame_start, frame_stop, rx_valid, tx_req;
  logic [7:0] rx_byte;
  logic [3:0] lock_nv = 4'h0;
  logic frozen_nv = 1'b0;
  logic ack_valid, ack_nack, tx_valid, busy, mem_wr_en, nv_prog_en, nv_prog_freeze;
  logic [7:0] tx_byte, mem_wr_data;
  logic [6:0] mem_wr_addr;
  logic [3:0] nv_prog_mask;
  int errors = 0;
  int samples_checked = 0;

  link_master_model m (.core_clk(core_clk), .frame_start(frame_start), .frame_stop(frame_stop),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req));
  eeprom_zone_write_lock #(.WRITE_CYCLES(WC)) uut (.core_clk(core_clk), .nrst(nrst),
    .dev_addr(DEV), .frame_start(frame_start), .frame_stop(frame_stop), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_req(tx_req), .nv_zone_lock(lock_nv), .nv_frozen(frozen_nv),
    .ack_valid(ack_valid), .ack_nack(ack_nack), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .busy(busy), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .nv_prog_en(nv_prog_en), .nv_prog_mask(nv_prog_mask), .nv_prog_freeze(nv_prog_freeze));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // Nonvolatile cells: set-only, untouched by reset.
  always @(posedge core_clk) begin
    if (nv_prog_en === 1'b1) begin
      if (nv_prog_freeze === 1'b1) begin
        frozen_nv <= 1'b1;
      end else begin
        lock_nv <= lock_nv | nv_prog_mask;
      end
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic ba(input logic [7:0] b, input logic nk);
    m.ev(2, b);
    chk(ack_valid, 1'b1);
    chk(ack_nack, nk);
    @(posedge core_clk);
    #1;
  endtask

  task automatic wait_prog(input logic frz);
    int n;
    n = 0;
    while (nv_prog_en !== 1'b1 && n < WC + 5) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == 1) chk(busy, 1'b1);
    end
    chk(n[7:0], WC[7:0]);
    chk(nv_prog_freeze, frz);
    if (n >= WC + 5) finish_test();
    @(posedge core_clk);
    #1;
  endtask

  task automatic query(input logic [7:0] sel, input logic [7:0] exp);
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b0}, 1'b0);
    ba(sel, 1'b0);
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b1}, 1'b0);
    m.ev(3, 8'h00);
    chk(tx_valid, 1'b1);
    chk(tx_byte, exp);
    m.ev(1, 8'h00);
  endtask

  task automatic lock_seq(input logic [7:0] sel, input logic nk);
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b0}, 1'b0);
    ba(sel, 1'b0);
    ba(8'hff, nk);
    m.ev(1, 8'h00);
  endtask

  task automatic t_lock();
    query(8'h04, 8'h00);
    lock_seq(8'h04, 1'b0);
    wait_prog(1'b0);
    chk(nv_prog_mask, 4'h4);
    query(8'hf4, 8'hff);
    query(8'h08, 8'h00);
    $display("test lock done");
  endtask

  task automatic t_abort();
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b0}, 1'b0);
    ba(8'h02, 1'b0);
    m.ev(1, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk(busy, 1'b0);
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b1}, 1'b1);
    m.ev(1, 8'h00);
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b0}, 1'b0);
    ba(8'h03, 1'b1);
    m.ev(1, 8'h00);
    m.ev(0, 8'h00);
    ba({OP_ZONE_LOCK, DEV, 1'b0}, 1'b0);
    ba(8'h02, 1'b0);
    ba(8'hfe, 1'b1);
    m.ev(1, 8'h00);
    m.ev(0, 8'h00);
    m.ev(2, {OP_ZONE_LOCK, 3'h2, 1'b0});
    chk(ack_valid, 1'b0);
    m.ev(1, 8'h00);
    query(8'h02, 8'h00);
    $display("test abort done");
  endtask

  task automatic wr(input logic [7:0] a, input logic nk);
    m.ev(0, 8'h00);
    ba({OP_MEM_WRITE, DEV, 1'b0}, 1'b0);
    ba(a, 1'b0);
    m.ev(2, 8'h3c);
    chk(ack_valid, 1'b1);
    chk(ack_nack, nk);
    chk(mem_wr_en, !nk);
    if (!nk) chk(mem_wr_addr, a[6:0]);
    if (!nk) chk(mem_wr_data, 8'h3c);
    m.ev(1, 8'h00);
  endtask

  task automatic t_write();
    wr(8'h3f, 1'b0);
    wr(8'h40, 1'b1);
    wr(8'h5f, 1'b1);
    wr(8'h60, 1'b0);
    $display("test write done");
  endtask

  task automatic t_freeze();
    m.ev(0, 8'h00);
    ba({OP_FREEZE, DEV, 1'b0}, 1'b0);
    ba(8'h56, 1'b1);
    m.ev(1, 8'h00);
    m.ev(0, 8'h00);
    ba({OP_FREEZE, DEV, 1'b0}, 1'b0);
    ba(8'h55, 1'b0);
    ba(8'haa, 1'b0);
    m.ev(1, 8'h00);
    wait_prog(1'b1);
    m.ev(0, 8'h00);
    ba({OP_FREEZE, DEV, 1'b0}, 1'b1);
    m.ev(1, 8'h00);
    lock_seq(8'h01, 1'b1);
    query(8'h01, 8'h00);
    $display("test freeze done");
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_lock();
    t_abort();
    t_write();
    t_freeze();
    finish_test();
  end
endmodule
